// ==== sbs_pkg.sv ====
// Purpose: shared constants of the serial bus status block
// Assumes: 32-bit register port with byte addresses
// Notes:   status word, interrupt mask and control word
//
// Contract
// R1 - slave address read-only at bits 7:1
// R2 - master address read-only at bits 15:9
// R3 - blank EEPROM sets bit 22 when loading
// R4 - bad dword count or end byte sets blank
// R5 - read address wrap sets bit 23
// R6 - bit 24 set on load end or error
// R7 - unexpected NACK on master bus sets bit 25
// R8 - misplaced START or STOP sets bit 27
// R9 - bad checksum or missing end sets 28
// R10 - write to unmapped register sets bit 29
// R11 - skip_load_check forces checksum to pass
// R12 - error flags write-one-clear, reserved read zero
package sbs_pkg;
    localparam logic [7:0]  ADDR_STATUS   = 8'h00;
    localparam logic [7:0]  ADDR_MASK     = 8'h04;
    localparam logic [7:0]  ADDR_CTL      = 8'h08;
    localparam int          SLV_LSB       = 1;
    localparam int          MST_LSB       = 9;
    localparam int          ADDR_BITS     = 7;
    localparam int          BLANK_BIT     = 22;
    localparam int          ROLL_BIT      = 23;
    localparam int          DONE_BIT      = 24;
    localparam int          NACK_BIT      = 25;
    localparam int          FRAME_BIT     = 27;
    localparam int          CKSUM_BIT     = 28;
    localparam int          UNMAP_BIT     = 29;
    localparam int          SKIP_BIT      = 17;
    localparam logic [31:0] W1C_MASK      = 32'h3AC0_0000;
    localparam logic [31:0] STS_MASK      = 32'h3BC0_0000;
    localparam logic [31:0] RSVD_MASK     = 32'hC43F_0101;
    localparam logic [7:0]  END_LOAD_BYTE = 8'hC0;
    localparam logic [3:0]  ACK_BIT_IDX   = 4'h8;
    localparam logic [1:0]  WARM_DONE     = 2'h3;
endpackage : sbs_pkg

// ==== sbs_evt_if.sv ====
// Purpose: event pulses from the bus monitor and load checker
// Assumes: all signals on clk_sys, one-cycle pulses
// Notes:   sink modport is the status register file
`timescale 1ns/10ps
interface sbs_evt_if;
    logic nack;
    logic frame_err;
    logic blank;
    logic rollover;
    logic done;
    logic cksum;
    logic unmapped;
    modport mon (output nack, output frame_err);
    modport ldr (output blank, output rollover, output done,
                 output cksum, output unmapped);
    modport sink (input nack, input frame_err, input blank,
                  input rollover, input done, input cksum,
                  input unmapped);
endinterface : sbs_evt_if

// ==== sbs_bus_mon.sv ====
// Purpose: watches the master bus lines for NACK and framing faults
// Assumes: scl and sda are pins sampled by clk_sys
// Notes:   pulses leave through the mon modport
`timescale 1ns/10ps
module sbs_bus_mon (
    input  logic       clk_sys,
    input  logic       nrst,
    input  logic       clk_en,
    input  logic       scl_pin,
    input  logic       sda_pin,
    input  logic       nack_ok,
    sbs_evt_if.mon     evt
);
    typedef struct packed {
        logic       scl_m, scl_s, scl_p;
        logic       sda_m, sda_s, sda_p;
        logic       busy;
        logic       seen;
        logic [3:0] bits;
        logic       nack, ferr;
    } sbs_mon_st_t;

    // idle lines read high, so no false edge follows reset
    localparam sbs_mon_st_t IDLE_ST = '{scl_m: 1'b1, scl_s: 1'b1,
        scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};

    sbs_mon_st_t q, d;
    logic        start_c, stop_c, rise_c, fall_c;

    ////////////////////////////////////////////////////////////////////
    // line conditions and bit position tracking
    always_comb begin
        d         = q;
        d.nack    = 1'b0;
        d.ferr    = 1'b0;
        d.scl_m   = scl_pin;
        d.scl_s   = q.scl_m;
        d.scl_p   = q.scl_s;
        d.sda_m   = sda_pin;
        d.sda_s   = q.sda_m;
        d.sda_p   = q.sda_s;
        start_c   = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
        stop_c    = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
        rise_c    = q.scl_s && !q.scl_p;
        fall_c    = !q.scl_s && q.scl_p;
        // a bit counts once its clock has risen and fallen again,
        // so the clock high ahead of a stop is not a data bit
        if (start_c || stop_c) begin
            d.ferr = q.busy && (q.bits != 4'h0); // R8
            d.busy = start_c;
            d.bits = 4'h0;
            d.seen = 1'b0;
        end else if (rise_c && q.busy) begin
            d.seen = 1'b1;
            d.nack = q.sda_s && !nack_ok // R7
                && (q.bits == sbs_pkg::ACK_BIT_IDX);
        end else if (fall_c && q.seen) begin
            d.seen = 1'b0;
            if (q.bits == sbs_pkg::ACK_BIT_IDX) begin
                d.bits = 4'h0;
            end else begin
                d.bits = q.bits + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= IDLE_ST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign evt.nack      = q.nack;
    assign evt.frame_err = q.ferr;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_nack_cause;
        @(posedge clk_sys) disable iff (!nrst)
        q.nack && $past(clk_en) |-> $past(q.busy && q.sda_s && !nack_ok
            && q.bits == sbs_pkg::ACK_BIT_IDX && q.scl_s && !q.scl_p);
    endproperty
    a_nack_cause: assert property (p_nack_cause) // R7
        else $error("nack flagged without a high ack bit");

    property p_frame_cause;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && q.busy && q.bits != 4'h0 && (start_c || stop_c)
            |=> q.ferr;
    endproperty
    a_frame_cause: assert property (p_frame_cause) // R8
        else $error("misplaced start or stop not flagged");
endmodule : sbs_bus_mon

// ==== sbs_load_chk.sv ====
// Purpose: turns loader engine reports into status events
// Assumes: loader reports are same-clock one-cycle pulses
// Notes:   every error also ends the load
`timescale 1ns/10ps
module sbs_load_chk (
    input  logic       clk_sys,
    input  logic       nrst,
    input  logic       clk_en,
    input  logic       load_en,
    input  logic       skip_check,
    input  logic       blank_det,
    input  logic       count_bad,
    input  logic       end_vld,
    input  logic [7:0] end_byte,
    input  logic       addr_wrap,
    input  logic       sum_bad,
    input  logic       end_missing,
    input  logic       unmapped_wr,
    input  logic       finish,
    sbs_evt_if.ldr     evt
);
    typedef struct packed {
        logic blank, roll, done, cksum, unmap;
    } sbs_ldr_st_t;

    sbs_ldr_st_t q, d;

    ////////////////////////////////////////////////////////////////////
    // event qualification, only while loading is enabled
    always_comb begin
        d = '0;
        if (load_en) begin
            d.blank = blank_det || count_bad // R3 R4
                || (end_vld && end_byte != sbs_pkg::END_LOAD_BYTE);
            d.roll  = addr_wrap; // R5
            d.cksum = (sum_bad && !skip_check) || end_missing; // R9 R11
            d.unmap = unmapped_wr; // R10
            d.done  = finish || d.blank || d.roll // R6
                || d.cksum || d.unmap;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign evt.blank    = q.blank;
    assign evt.rollover = q.roll;
    assign evt.done     = q.done;
    assign evt.cksum    = q.cksum;
    assign evt.unmapped = q.unmap;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_end_byte;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && load_en && end_vld
            && end_byte != sbs_pkg::END_LOAD_BYTE |=> q.blank && q.done;
    endproperty
    a_end_byte: assert property (p_end_byte) // R4
        else $error("bad end byte not flagged as blank");

    property p_skip;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && skip_check && !end_missing |=> !q.cksum;
    endproperty
    a_skip: assert property (p_skip) // R11
        else $error("checksum flagged while checks skipped");
endmodule : sbs_load_chk

// ==== sbs_top.sv ====
// Purpose: serial bus status word, interrupt mask and control
// Assumes: register strobes on clk_sys, straps and bus lines are pins
// Notes:   read data appear only in the cycle after the read strobe
`timescale 1ns/10ps
module sbs_top #(
    parameter int ADDR_W = 8
) (
    input  logic              clk_sys,
    input  logic              nrst,
    input  logic              clk_en,
    input  logic [ADDR_W-1:0] reg_addr,
    input  logic [31:0]       reg_wdata,
    input  logic              reg_wr,
    input  logic              reg_rd,
    output logic [31:0]       reg_rdata,
    output logic              irq,
    input  logic [6:0]        slv_addr_strap,
    input  logic [6:0]        mst_addr_strap,
    input  logic              load_mode_strap,
    output logic              load_enable,
    output logic              skip_load_check,
    input  logic              mst_scl,
    input  logic              mst_sda,
    input  logic              nack_ok,
    input  logic              ld_blank,
    input  logic              ld_count_bad,
    input  logic              ld_end_vld,
    input  logic [7:0]        ld_end_byte,
    input  logic              ld_wrap,
    input  logic              ld_sum_bad,
    input  logic              ld_end_missing,
    input  logic              ld_unmapped,
    input  logic              ld_finish
);
    if (ADDR_W < 4 || ADDR_W > 16) begin : g_addr_chk
        $error("ADDR_W must lie between 4 and 16");
    end

    typedef struct packed {
        logic [6:0]  sa_m, sa_s, ma_m, ma_s;
        logic        mode_m, mode_s;
        logic [1:0]  warm;
        logic [6:0]  slv, mst;
        logic        load_mode;
        logic [31:0] sts, mask;
        logic        skip;
        logic [31:0] rdata;
        logic        irq;
    } sbs_top_st_t;

    sbs_top_st_t q, d;
    sbs_evt_if   evt ();
    logic [31:0] ev_c;
    logic [31:0] clr_c;

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        off);
        return a == ADDR_W'(off);
    endfunction : hit

    function automatic logic [31:0] status_word(input sbs_top_st_t s);
        logic [31:0] w;
        w = s.sts & sbs_pkg::STS_MASK;
        w[sbs_pkg::SLV_LSB +: sbs_pkg::ADDR_BITS] = s.slv; // R1
        w[sbs_pkg::MST_LSB +: sbs_pkg::ADDR_BITS] = s.mst; // R2
        return w;
    endfunction : status_word

    ////////////////////////////////////////////////////////////////////
    // event sources
    sbs_bus_mon u_mon (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .scl_pin (mst_scl),
        .sda_pin (mst_sda),
        .nack_ok (nack_ok),
        .evt     (evt.mon)
    );

    sbs_load_chk u_ldr (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .clk_en      (clk_en),
        .load_en     (q.load_mode),
        .skip_check  (q.skip),
        .blank_det   (ld_blank),
        .count_bad   (ld_count_bad),
        .end_vld     (ld_end_vld),
        .end_byte    (ld_end_byte),
        .addr_wrap   (ld_wrap),
        .sum_bad     (ld_sum_bad),
        .end_missing (ld_end_missing),
        .unmapped_wr (ld_unmapped),
        .finish      (ld_finish),
        .evt         (evt.ldr)
    );

    ////////////////////////////////////////////////////////////////////
    // event vector in status layout
    always_comb begin
        ev_c                      = '0;
        ev_c[sbs_pkg::BLANK_BIT]  = evt.blank;
        ev_c[sbs_pkg::ROLL_BIT]   = evt.rollover;
        ev_c[sbs_pkg::DONE_BIT]   = evt.done;
        ev_c[sbs_pkg::NACK_BIT]   = evt.nack;
        ev_c[sbs_pkg::FRAME_BIT]  = evt.frame_err;
        ev_c[sbs_pkg::CKSUM_BIT]  = evt.cksum;
        ev_c[sbs_pkg::UNMAP_BIT]  = evt.unmapped;
        clr_c = '0;
        if (reg_wr && hit(reg_addr, sbs_pkg::ADDR_STATUS)) begin
            clr_c = reg_wdata & sbs_pkg::W1C_MASK; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state: straps, flags, registers, read data, interrupt
    always_comb begin
        d        = q;
        d.sa_m   = slv_addr_strap;
        d.sa_s   = q.sa_m;
        d.ma_m   = mst_addr_strap;
        d.ma_s   = q.ma_m;
        d.mode_m = load_mode_strap;
        d.mode_s = q.mode_m;
        // straps caught once the synchronisers have filled
        if (q.warm != sbs_pkg::WARM_DONE) begin
            d.warm = q.warm + 2'h1;
            if (d.warm == sbs_pkg::WARM_DONE) begin
                d.slv       = q.sa_s; // R1
                d.mst       = q.ma_s; // R2
                d.load_mode = q.mode_s;
            end
        end
        // set beats clear; done bit is cleared only by reset
        d.sts = ((q.sts & ~clr_c) | ev_c) & sbs_pkg::STS_MASK; // R12 R6
        if (reg_wr && hit(reg_addr, sbs_pkg::ADDR_MASK)) begin
            d.mask = reg_wdata & sbs_pkg::W1C_MASK;
        end
        if (reg_wr && hit(reg_addr, sbs_pkg::ADDR_CTL)) begin
            d.skip = reg_wdata[sbs_pkg::SKIP_BIT]; // R11
        end
        d.rdata = '0;
        if (reg_rd) begin
            if (hit(reg_addr, sbs_pkg::ADDR_STATUS)) begin
                d.rdata = status_word(q); // R12
            end else if (hit(reg_addr, sbs_pkg::ADDR_MASK)) begin
                d.rdata = q.mask;
            end else if (hit(reg_addr, sbs_pkg::ADDR_CTL)) begin
                d.rdata[sbs_pkg::SKIP_BIT] = q.skip;
            end
        end
        d.irq = |(d.sts & d.mask & sbs_pkg::W1C_MASK);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign reg_rdata       = q.rdata;
    assign irq             = q.irq;
    assign load_enable     = q.load_mode;
    assign skip_load_check = q.skip;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_slv_read;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && reg_rd && hit(reg_addr, sbs_pkg::ADDR_STATUS)
            |=> reg_rdata[7:1] == $past(q.slv);
    endproperty
    a_slv_read: assert property (p_slv_read) // R1
        else $error("status read lost the slave address");

    property p_mst_fixed;
        @(posedge clk_sys) disable iff (!nrst)
        q.warm == sbs_pkg::WARM_DONE |=> $stable(q.mst) && $stable(q.slv);
    endproperty
    a_mst_fixed: assert property (p_mst_fixed) // R2
        else $error("bus address changed after capture");

    property p_blank_set;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && evt.blank |=> q.sts[22];
    endproperty
    a_blank_set: assert property (p_blank_set) // R3
        else $error("blank event did not set its flag");

    property p_roll_set;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && evt.rollover |=> q.sts[23] ##0 q.sts[24][*1];
    endproperty
    a_roll_set: assert property (p_roll_set) // R5
        else $error("rollover did not set flag and done");

    property p_done_hold;
        @(posedge clk_sys) disable iff (!nrst)
        q.sts[24] |=> q.sts[24][*3];
    endproperty
    a_done_hold: assert property (p_done_hold) // R6
        else $error("load complete flag fell");

    property p_nack_set;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && evt.nack && reg_wr |=> q.sts[25];
    endproperty
    a_nack_set: assert property (p_nack_set) // R7
        else $error("nack lost against a clear");

    property p_frame_set;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && evt.frame_err |=> q.sts[27] ##1 (q.sts[27] || $past(reg_wr));
    endproperty
    a_frame_set: assert property (p_frame_set) // R8
        else $error("framing flag not held");

    property p_cksum_set;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && evt.cksum |=> q.sts[28] && q.sts[24];
    endproperty
    a_cksum_set: assert property (p_cksum_set) // R9
        else $error("checksum error not flagged");

    property p_unmap_set;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && q.load_mode && ld_unmapped |=> ##1 q.sts[29];
    endproperty
    a_unmap_set: assert property (p_unmap_set) // R10
        else $error("unmapped write not flagged");

    property p_w1c;
        @(posedge clk_sys) disable iff (!nrst)
        clk_en && hit(reg_addr, sbs_pkg::ADDR_STATUS) && reg_wr
            && !evt.nack |=> q.sts[25] == ($past(q.sts[25])
            && !$past(reg_wdata[25]));
    endproperty
    a_w1c: assert property (p_w1c) // R12
        else $error("write one clear misbehaved");

    property p_rsvd;
        @(posedge clk_sys) disable iff (!nrst)
        (reg_rdata & sbs_pkg::RSVD_MASK) == 32'h0000_0000 || !$past(reg_rd)
            || !$past(hit(reg_addr, sbs_pkg::ADDR_STATUS));
    endproperty
    a_rsvd: assert property (p_rsvd) // R12
        else $error("reserved status bit read non-zero");

    property p_irq;
        @(posedge clk_sys) disable iff (!nrst)
        $past(clk_en) |-> irq == |(q.sts & q.mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt disagrees with masked status");
endmodule : sbs_top

// ==== sbs_smb_peer.sv ====
// Purpose: far-side model of the master bus, an eeprom or other target
// Assumes: open-drain lines with pull-ups, clock of 125 ns in frames
// Notes:   lines are released (high) outside frames, scl stands still
`timescale 1ns/10ps
module sbs_smb_peer (
    output logic scl,
    output logic sda
);
    localparam real HALF = 62.5;

    ////////////////////////////////////////////////////////////////////
    // released lines read high through the pull-ups
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // start: data falls while clock is high
    task start_c;
        sda = 1'b0;
        #(HALF);
        scl = 1'b0;
        #(HALF);
    endtask : start_c

    // one bit: data moves only while clock is low
    task bit_c(input logic b);
        sda = b;
        #(HALF);
        scl = 1'b1;
        #(HALF);
        scl = 1'b0;
    endtask : bit_c

    // stop: data rises while clock is high, then both released
    task stop_c;
        sda = 1'b0;
        #(HALF);
        scl = 1'b1;
        #(HALF);
        sda = 1'b1;
        #(HALF);
    endtask : stop_c

    // full byte frame; last bit high is a nack from the target
    task frame_c(input logic [7:0] d, input logic ack_hi);
        start_c();
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i]);
        end
        bit_c(ack_hi);
        stop_c();
    endtask : frame_c
endmodule : sbs_smb_peer

// ==== sbs_top_test.sv ====
// Purpose: self-checking bench of the serial bus status block
// Assumes: register port answers one cycle after the read strobe
// Notes:   loader pulses driven here, bus lines from the peer model
`timescale 1ns/10ps
module sbs_top_test;
    localparam logic [6:0] SLV = 7'h2B;
    localparam logic [6:0] MST = 7'h51;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        clk_en = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        irq;
    logic        load_enable;
    logic        skip_load_check;
    logic        scl;
    logic        sda;
    logic        nack_ok = 1'b0;
    logic        load_mode = 1'b1;
    logic [6:0]  ld_p = 7'h00;
    logic        ld_end_vld = 1'b0;
    logic [7:0]  ld_end_byte = 8'h00;
    logic [31:0] base;
    logic [31:0] done_w;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          bits [6] = '{22, 22, 23, 28, 28, 29};

    always #2.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////
    // design and far-side model
    sbs_top #(.ADDR_W(8)) sbs_top_inst (
        .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .slv_addr_strap(SLV), .mst_addr_strap(MST),
        .load_mode_strap(load_mode), .load_enable(load_enable),
        .skip_load_check(skip_load_check), .mst_scl(scl), .mst_sda(sda),
        .nack_ok(nack_ok), .ld_blank(ld_p[0]), .ld_count_bad(ld_p[1]),
        .ld_end_vld(ld_end_vld), .ld_end_byte(ld_end_byte),
        .ld_wrap(ld_p[2]), .ld_sum_bad(ld_p[3]),
        .ld_end_missing(ld_p[4]), .ld_unmapped(ld_p[5]),
        .ld_finish(ld_p[6])
    );
    sbs_smb_peer sbs_smb_peer_inst (.scl(scl), .sda(sda));

    ////////////////////////////////////////////////////////////////////
    // verdict, compare and access tasks
    task conclude;
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // one-cycle loader pulse, then time for the status to land
    task pulse(input int i);
        @(posedge clk_sys);
        ld_p <= 7'(1 << i);
        @(posedge clk_sys);
        ld_p <= 7'h00;
        repeat (4) @(posedge clk_sys);
    endtask : pulse

    task end_seq(input logic [7:0] b);
        @(posedge clk_sys);
        ld_end_vld  <= 1'b1;
        ld_end_byte <= b;
        @(posedge clk_sys);
        ld_end_vld  <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : end_seq

    ////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        base   = (32'(SLV) << sbs_pkg::SLV_LSB) | (32'(MST) << sbs_pkg::MST_LSB);
        done_w = base | (32'h1 << sbs_pkg::DONE_BIT);
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(sbs_pkg::ADDR_STATUS, base);
        chk(32'(load_enable), 32'h1);
        // read data stand one cycle only, then zero
        @(posedge clk_sys);
        #1;
        chk(reg_rdata, 32'h0000_0000);
        wr(sbs_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rd(sbs_pkg::ADDR_STATUS, base);
        rd(sbs_pkg::ADDR_MASK, 32'h0000_0000);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0000_0000);
        pulse(6);
        rd(sbs_pkg::ADDR_STATUS, done_w);
        // each loader fault sets its flag, write-one clears it
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            rd(sbs_pkg::ADDR_STATUS, done_w | (32'h1 << bits[i]));
            wr(sbs_pkg::ADDR_STATUS, 32'h1 << bits[i]);
            rd(sbs_pkg::ADDR_STATUS, done_w);
        end
        end_seq(sbs_pkg::END_LOAD_BYTE);
        rd(sbs_pkg::ADDR_STATUS, done_w);
        end_seq(8'h5A);
        rd(sbs_pkg::ADDR_STATUS, done_w | 32'h0040_0000);
        // zero write and a strobe while frozen leave the flag set
        wr(sbs_pkg::ADDR_STATUS, 32'h0000_0000);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(sbs_pkg::ADDR_STATUS, 32'h0040_0000);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        rd(sbs_pkg::ADDR_STATUS, done_w | 32'h0040_0000);
        // interrupt follows status and mask
        wr(sbs_pkg::ADDR_MASK, 32'hFFFF_FFFF);
        rd(sbs_pkg::ADDR_MASK, sbs_pkg::W1C_MASK);
        repeat (3) @(posedge clk_sys);
        chk(32'(irq), 32'h1);
        wr(sbs_pkg::ADDR_MASK, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        wr(sbs_pkg::ADDR_STATUS, 32'h0040_0000);
        rd(sbs_pkg::ADDR_STATUS, done_w);
        // skip bit hides a checksum fault
        wr(sbs_pkg::ADDR_CTL, 32'h0002_0000);
        rd(sbs_pkg::ADDR_CTL, 32'h0002_0000);
        chk(32'(skip_load_check), 32'h1);
        pulse(3);
        rd(sbs_pkg::ADDR_STATUS, done_w);
        wr(sbs_pkg::ADDR_CTL, 32'h0000_0000);
        // unexpected nack on the master bus
        sbs_smb_peer_inst.frame_c(8'hA6, 1'b1);
        repeat (8) @(posedge clk_sys);
        rd(sbs_pkg::ADDR_STATUS, done_w | 32'h0200_0000);
        wr(sbs_pkg::ADDR_STATUS, 32'h0200_0000);
        // expected nack passes quietly
        nack_ok <= 1'b1;
        sbs_smb_peer_inst.frame_c(8'h5B, 1'b1);
        repeat (8) @(posedge clk_sys);
        nack_ok <= 1'b0;
        rd(sbs_pkg::ADDR_STATUS, done_w);
        // stop in mid-byte is a framing fault
        sbs_smb_peer_inst.start_c();
        sbs_smb_peer_inst.bit_c(1'b1);
        sbs_smb_peer_inst.bit_c(1'b0);
        sbs_smb_peer_inst.bit_c(1'b1);
        sbs_smb_peer_inst.stop_c();
        repeat (8) @(posedge clk_sys);
        rd(sbs_pkg::ADDR_STATUS, done_w | 32'h0800_0000);
        wr(sbs_pkg::ADDR_STATUS, 32'h0800_0000);
        rd(sbs_pkg::ADDR_STATUS, done_w);
        // second reset with loading strapped off: loader pulses refused
        @(posedge clk_sys);
        nrst      <= 1'b0;
        load_mode <= 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(32'(load_enable), 32'h0);
        pulse(0);
        pulse(5);
        rd(sbs_pkg::ADDR_STATUS, base);
        conclude();
    end
endmodule : sbs_top_test
